// File: include/uft_pkg.sv
package uft_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 20;
    localparam int POR_PULSE_NS        = 800;
    localparam int POR_PULSE_CYC       = POR_PULSE_NS / CLK_PERIOD_NS;
    localparam int DIP_FILTER_US       = 11;
    localparam int DIP_FILTER_CYC      = (DIP_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W               = 10;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] RXLOG_OFFSET  = 8'h08;

    // Control fields
    localparam int CTRL_DATA_SE0_BIT  = 0;
    localparam int CTRL_BIDIR_BIT     = 1;
    localparam int CTRL_LOG_EN_BIT    = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Buffer of receive samples
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Internal reset generator states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        UFT_POR_PULSE = 2'b00,
        UFT_POR_IDLE  = 2'b01,
        UFT_POR_DIP   = 2'b11
    } uft_por_state_t;
endpackage : uft_pkg

// File: logic/uft_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module uft_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,   // Clock
    input  wire logic             rstn,      // Async reset, active low
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    input  wire logic             in_valid,  // Write request
    output var  logic             in_ready,  // Not full
    output var  logic [WIDTH-1:0] out_data,  // Read data
    output var  logic             out_valid, // Not empty
    input  wire logic             out_ready  // Read accept
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop  ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem[rd_q[AW-1:0]];

    fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_q - rd_q) <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : uft_fifo
`default_nettype wire

// File: logic/uft_xcvr.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module uft_xcvr
    import uft_pkg::*;
(
    input  wire logic        ref_clk,          // 50 MHz clock
    input  wire logic        rstn,             // Async reset, active low
    // Controller side
    input  wire logic        reset_pin_n,      // Reset pin, active low
    input  wire logic        oe_n,             // Output enable, active low
    input  wire logic        suspend,          // Suspend
    input  wire logic        vcc_ok,           // Core supply above trip
    input  wire logic        tx_data_plus_i,   // Data/plus pin in
    output logic             tx_data_plus_o,   // Data/plus pin out
    output logic             tx_data_plus_oe,  // Data/plus pin enable
    input  wire logic        se0_minus_i,      // SE0/minus pin in
    output logic             se0_minus_o,      // SE0/minus pin out
    output logic             se0_minus_oe,     // SE0/minus pin enable
    output logic             diff_receive_out, // Differential receive
    output logic             por_active,       // Internal reset pulse
    // Line side
    input  wire logic        dp_i,             // DP line in
    input  wire logic        dm_i,             // DM line in
    input  wire logic        rx_diff,          // Differential comparator
    output logic             dp_o,             // DP drive
    output logic             dm_o,             // DM drive
    output logic             line_oe,          // Driver enable
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,         // Write address
    input  wire logic        s_awvalid,        // Write address valid
    output logic             s_awready,        // Write address ready
    input  wire logic [31:0] s_wdata,          // Write data
    input  wire logic [3:0]  s_wstrb,          // Write strobes
    input  wire logic        s_wvalid,         // Write data valid
    output logic             s_wready,         // Write data ready
    output logic [1:0]       s_bresp,          // Write response
    output logic             s_bvalid,         // Write response valid
    input  wire logic        s_bready,         // Write response ready
    input  wire logic [7:0]  s_araddr,         // Read address
    input  wire logic        s_arvalid,        // Read address valid
    output logic             s_arready,        // Read address ready
    output logic [31:0]      s_rdata,          // Read data
    output logic [1:0]       s_rresp,          // Read response
    output logic             s_rvalid,         // Read data valid
    input  wire logic        s_rready          // Read data ready
);
    // ----------------------------------------------------------------
    // Internal power-on reset
    // ----------------------------------------------------------------
    uft_por_state_t   por_st_q, por_st_d;
    logic [CNT_W-1:0] por_cnt_q, por_cnt_d;
    logic             por_q, por_d;

    always_comb begin
        por_st_d  = por_st_q;
        por_cnt_d = por_cnt_q;
        por_d     = por_q;
        case (por_st_q)
            UFT_POR_PULSE: begin
                por_d = 1'b1;
                if (!vcc_ok) begin
                    por_cnt_d = '0;
                end else if (por_cnt_q >= CNT_W'(POR_PULSE_CYC - 1)) begin
                    por_st_d  = UFT_POR_IDLE;
                    por_d     = 1'b0;
                    por_cnt_d = '0;
                end else begin
                    por_cnt_d = por_cnt_q + 1'b1;
                end
            end
            UFT_POR_IDLE: begin
                por_cnt_d = '0;
                if (!vcc_ok) begin
                    por_st_d = UFT_POR_DIP;
                end
            end
            UFT_POR_DIP: begin
                if (vcc_ok) begin
                    por_st_d  = UFT_POR_IDLE;
                    por_cnt_d = '0;
                end else if (por_cnt_q >= CNT_W'(DIP_FILTER_CYC - 1)) begin
                    por_st_d  = UFT_POR_PULSE;
                    por_d     = 1'b1;
                    por_cnt_d = '0;
                end else begin
                    por_cnt_d = por_cnt_q + 1'b1;
                end
            end
            default: begin
                por_st_d = UFT_POR_PULSE;
                por_d    = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            por_st_q  <= UFT_POR_PULSE;
            por_cnt_q <= '0;
            por_q     <= 1'b1;
        end else begin
            por_st_q  <= por_st_d;
            por_cnt_q <= por_cnt_d;
            por_q     <= por_d;
        end
    end

    // ----------------------------------------------------------------
    // Transceiver datapath
    // ----------------------------------------------------------------
    logic [$bits(CTRL_RESET)-1:0] ctrl_q, ctrl_d;
    wire  data_se0_encoding        = ctrl_q[CTRL_DATA_SE0_BIT];
    wire  paired_line_encoding     = !data_se0_encoding;
    wire  bidirectional_pin_select = ctrl_q[CTRL_BIDIR_BIT];

    function automatic logic is_jk(input logic p, input logic m);
        return p ^ m;
    endfunction

    logic rcv_hold_q, rcv_hold_d;
    logic dp_d, dm_d, oe_d, rcv_d;
    logic dpo_d, dpoe_d, smo_d, smoe_d;

    always_comb begin
        dp_d = 1'b0;
        dm_d = 1'b0;
        oe_d = reset_pin_n && !por_q && !oe_n;
        if (suspend) begin
            dp_d = tx_data_plus_i;
            dm_d = !tx_data_plus_i;
        end else if (paired_line_encoding) begin
            dp_d = tx_data_plus_i;
            dm_d = se0_minus_i;
        end else if (!se0_minus_i) begin
            dp_d = tx_data_plus_i;
            dm_d = !tx_data_plus_i;
        end
        rcv_hold_d = rcv_hold_q;
        if (!oe_n) begin
            rcv_hold_d = 1'b0;
        end else if (!suspend && is_jk(dp_i, dm_i)) begin
            rcv_hold_d = rx_diff;
        end
        rcv_d  = rcv_hold_d;
        dpo_d  = 1'b0;
        smo_d  = 1'b0;
        dpoe_d = 1'b0;
        smoe_d = 1'b0;
        if (oe_n && bidirectional_pin_select) begin
            dpoe_d = 1'b1;
            smoe_d = 1'b1;
            if (paired_line_encoding) begin
                dpo_d = dp_i;
                smo_d = dm_i;
            end else if (suspend) begin
                dpo_d = dp_i;
                smo_d = !dp_i && !dm_i;
            end else begin
                dpo_d = is_jk(dp_i, dm_i) ? dp_i : rcv_hold_q;
                smo_d = !dp_i && !dm_i;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dp_o             <= 1'b0;
            dm_o             <= 1'b0;
            line_oe          <= 1'b0;
            rcv_hold_q       <= 1'b0;
            diff_receive_out <= 1'b0;
            tx_data_plus_o   <= 1'b0;
            tx_data_plus_oe  <= 1'b0;
            se0_minus_o      <= 1'b0;
            se0_minus_oe     <= 1'b0;
        end else begin
            dp_o             <= dp_d;
            dm_o             <= dm_d;
            line_oe          <= oe_d;
            rcv_hold_q       <= rcv_hold_d;
            diff_receive_out <= rcv_d;
            tx_data_plus_o   <= dpo_d;
            tx_data_plus_oe  <= dpoe_d;
            se0_minus_o      <= smo_d;
            se0_minus_oe     <= smoe_d;
        end
    end
    assign por_active = por_q;

    // ----------------------------------------------------------------
    // Receive sample log
    // ----------------------------------------------------------------
    logic [FIFO_W-1:0] fifo_out;
    logic              fifo_ovalid, fifo_iready, fifo_pop;
    wire  log_push = ctrl_q[CTRL_LOG_EN_BIT] && oe_n && !suspend;

    uft_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_data   ({5'h00, dp_i, dm_i, rx_diff}),
        .in_valid  (log_push),
        .in_ready  (fifo_iready),
        .out_data  (fifo_out),
        .out_valid (fifo_ovalid),
        .out_ready (fifo_pop)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic        aw_q, aw_d, w_q, w_d, bv_d, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_d;
    logic [1:0]  br_d, rr_d;

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ctrl_d = ctrl_q;
        bv_d = s_bvalid && !s_bready;
        br_d = s_bresp;
        rv_d = s_rvalid && !s_rready;
        rr_d = s_rresp;
        rd_d = s_rdata;
        fifo_pop = 1'b0;
        if (s_awvalid && s_awready) begin
            aw_d = 1'b1;
            awa_d = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_d = 1'b1;
            wd_d = s_wdata;
        end
        if (aw_q && w_q && !s_bvalid) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = RESP_OKAY;
            if (awa_q == CTRL_OFFSET) begin
                if (s_wstrb[0]) ctrl_d = wd_q[2:0];
            end else if (awa_q != STATUS_OFFSET && awa_q != RXLOG_OFFSET) begin
                br_d = RESP_SLVERR;
            end
        end
        if (s_arvalid && s_arready) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            case (s_araddr)
                CTRL_OFFSET:   rd_d = {29'h0, ctrl_q};
                STATUS_OFFSET: rd_d = {24'h0, fifo_ovalid, !fifo_iready, por_q, line_oe,
                                       rcv_hold_q, dp_i, dm_i, suspend};
                RXLOG_OFFSET: begin
                    rd_d = {23'h0, fifo_ovalid, fifo_out};
                    fifo_pop = fifo_ovalid;
                end
                default: begin
                    rd_d = 32'h0;
                    rr_d = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            ctrl_q <= CTRL_RESET;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            s_rvalid <= 1'b0;
            s_rresp <= RESP_OKAY;
            s_rdata <= 32'h0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_arready <= 1'b0;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ctrl_q <= ctrl_d;
            s_bvalid <= bv_d;
            s_bresp <= br_d;
            s_rvalid <= rv_d;
            s_rresp <= rr_d;
            s_rdata <= rd_d;
            s_awready <= !aw_d && !(s_awvalid && s_awready);
            s_wready <= !w_d && !(s_wvalid && s_wready);
            s_arready <= !rv_d && !(s_arvalid && s_arready);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    drv_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (oe_n || !reset_pin_n || por_q) |=> !line_oe) else $error("driver on during disable");
    paired_tx_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!suspend && paired_line_encoding) |=> (dp_o == $past(tx_data_plus_i) && dm_o == $past(se0_minus_i)))
        else $error("paired drive mismatch");
    se0_tx_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!suspend && data_se0_encoding && se0_minus_i) |=> (!dp_o && !dm_o)) else $error("se0 not driven");
    susp_tx_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        suspend |=> (dp_o == $past(tx_data_plus_i) && dm_o == !$past(tx_data_plus_i)))
        else $error("suspend drive not differential");
    rcv_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !oe_n |=> !diff_receive_out) else $error("receive not forced low");
    rcv_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (oe_n && !suspend && !is_jk(dp_i, dm_i)) |=> $stable(rcv_hold_q)) else $error("hold changed");
    uni_pins_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !bidirectional_pin_select |=> (!tx_data_plus_oe && !se0_minus_oe)) else $error("pin driven unidirectional");
    por_len_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (vcc_ok && por_st_q == UFT_POR_PULSE && por_cnt_q == '0 && $past(vcc_ok)) |-> por_q [*8])
        else $error("reset pulse short");
    dip_filter_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (por_st_q == UFT_POR_DIP && vcc_ok) |=> !por_q) else $error("short dip reacted");
    se0_detect_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (oe_n && bidirectional_pin_select && data_se0_encoding && suspend && !dp_i && !dm_i)
        |=> se0_minus_o) else $error("se0 not reported");

    por_done_c: cover property (@(posedge ref_clk) disable iff (!rstn) $fell(por_q));
    dip_restart_c: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(por_q));
    tx_enable_c: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(line_oe));
    log_full_c: cover property (@(posedge ref_clk) disable iff (!rstn) !fifo_iready);
endmodule : uft_xcvr
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import uft_pkg::*;
    typedef struct packed {
        logic [8:0] i;
        logic [7:0] e;
    } uft_row_t;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic             ref_clk = 1'h0;
    logic             rstn = 1'h0;
    logic             vcc_ok = 1'h0;
    logic             c_rst = 1'h1, c_oe = 1'h1, c_sus = 1'h0, c_p = 1'h0, c_m = 1'h0, bidir = 1'h0;
    logic             dp_i = 1'h0, dm_i = 1'h0, rx_diff = 1'h0;
    logic [7:0]       s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0]      s_wdata = 32'h0;
    logic [3:0]       s_wstrb = 4'h0;
    logic             s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
    wire logic        reset_pin_n, oe_n, suspend, tx_data_plus_i, se0_minus_i, tx_data_plus_o, tx_data_plus_oe;
    wire logic        se0_minus_o, se0_minus_oe, diff_receive_out, por_active, dp_o, dm_o, line_oe;
    wire logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire logic [1:0]  s_bresp, s_rresp;
    wire logic [31:0] s_rdata;
    int               fail_count = 0, total_checks = 0, cycles = 0, n = 0;
    logic [31:0]      d;
    logic [1:0]       r;
    logic [7:0]       seen, m;
    logic [2:0]       ctl = 3'h0;
    logic             hit;
    // Inputs {mode, bidir, oe_n, suspend, dplus, se0m, dp, dm, rxd}
    // Outputs {line_oe, dp, dm, rcv, p_oe, p, m_oe, m}
    uft_row_t rows [24] = '{
        {9'b000000000, 8'b10000000}, {9'b000010000, 8'b11000000}, {9'b000001000, 8'b10100000},
        {9'b000011000, 8'b11100000}, {9'b100000000, 8'b10100000}, {9'b100010000, 8'b11000000},
        {9'b100001000, 8'b10000000}, {9'b100011000, 8'b10000000}, {9'b000111000, 8'b11000000},
        {9'b100100000, 8'b10100000}, {9'b001000101, 8'b00010000}, {9'b001000000, 8'b00010000},
        {9'b101000010, 8'b00000000}, {9'b011000010, 8'b00001011}, {9'b011000111, 8'b00001111},
        {9'b011100100, 8'b00001110}, {9'b111000101, 8'b00011110}, {9'b111000000, 8'b00011111},
        {9'b111000110, 8'b00011110}, {9'b111000010, 8'b00001010}, {9'b111000001, 8'b00001011},
        {9'b111100000, 8'b00001011}, {9'b111100110, 8'b00001110}, {9'b111100010, 8'b00001010}
    };
    uft_link_model link (
        .ref_clk, .cmd_reset_n(c_rst), .cmd_oe_n(c_oe), .cmd_suspend(c_sus), .cmd_p(c_p), .cmd_m(c_m),
        .bidir, .p_o(tx_data_plus_o), .p_oe(tx_data_plus_oe), .m_o(se0_minus_o), .m_oe(se0_minus_oe),
        .reset_pin_n, .oe_n, .suspend, .pin_p(tx_data_plus_i), .pin_m(se0_minus_i)
    );
    uft_xcvr dut (
        .ref_clk, .rstn, .reset_pin_n, .oe_n, .suspend, .vcc_ok, .tx_data_plus_i, .tx_data_plus_o,
        .tx_data_plus_oe, .se0_minus_i, .se0_minus_o, .se0_minus_oe, .diff_receive_out, .por_active,
        .dp_i, .dm_i, .rx_diff, .dp_o, .dm_o, .line_oe, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready
    );
    always #10 ref_clk = !ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [63:0] sv, input logic [63:0] ev, input string msg);
        total_checks++;
        if (sv !== ev) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, sv, ev);
        end
    endtask : check
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge ref_clk);
        s_awaddr  <= a;
        s_awvalid <= 1'h1;
        s_wdata   <= dv;
        s_wstrb   <= 4'hf;
        s_wvalid  <= 1'h1;
        s_bready  <= 1'h1;
        forever begin
            @(posedge ref_clk);
            if (s_bvalid === 1'h1 && !aw && !w) begin
                rv = s_bresp;
                s_bready <= 1'h0;
                break;
            end
            if (aw && s_awready === 1'h1) begin
                aw = 1'h0;
                s_awvalid <= 1'h0;
            end
            if (w && s_wready === 1'h1) begin
                w = 1'h0;
                s_wvalid <= 1'h0;
            end
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
        @(posedge ref_clk);
        s_araddr  <= a;
        s_arvalid <= 1'h1;
        s_rready  <= 1'h1;
        forever begin
            @(posedge ref_clk);
            if (s_rvalid === 1'h1 && !s_arvalid) begin
                dv = s_rdata;
                rv = s_rresp;
                s_rready <= 1'h0;
                break;
            end
            if (s_arvalid && s_arready === 1'h1) s_arvalid <= 1'h0;
        end
    endtask : axi_rd
    task automatic por_len();
        n = 0;
        while (por_active !== 1'h0 && n < 200) begin
            @(posedge ref_clk);
            n++;
            if (n == 20) check(line_oe, 1'h0, "driver during pulse");
        end
        check(n >= 39 && n <= 43, 1'h1, "pulse length");
    endtask : por_len
    task automatic dip(input int len);
        hit = 1'h0;
        vcc_ok <= 1'h0;
        for (int k = 0; k < len + 1; k++) begin
            @(posedge ref_clk);
            hit |= por_active;
            vcc_ok <= (k >= len - 1);
        end
    endtask : dip
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        check(por_active, 1'h1, "pulse in reset");
        check(line_oe, 1'h0, "driver in reset");
        rstn <= 1'h1;
        c_oe <= 1'h0;
        repeat (5) @(posedge ref_clk);
        vcc_ok <= 1'h1;
        por_len();
        repeat (4) @(posedge ref_clk);
        check(line_oe, 1'h1, "driver on");
        dip(545);
        check(hit, 1'h0, "short dip");
        dip(556);
        check(hit, 1'h1, "long dip");
        por_len();
        @(posedge ref_clk);
        c_rst <= 1'h0;
        repeat (4) @(posedge ref_clk);
        check(line_oe, 1'h0, "reset pin low");
        c_rst <= 1'h1;
        axi_rd(CTRL_OFFSET, d, r);
        check(d[2:0], CTRL_RESET, "control reset value");
        axi_rd(8'h0c, d, r);
        check({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
        axi_wr(8'h0c, 32'h0, r);
        check(r, RESP_SLVERR, "unmapped write");
        foreach (rows[k]) begin
            if ({1'h0, rows[k].i[7], rows[k].i[8]} !== ctl) begin
                ctl = {1'h0, rows[k].i[7], rows[k].i[8]};
                axi_wr(CTRL_OFFSET, {29'h0, ctl}, r);
            end
            @(posedge ref_clk);
            {bidir, c_oe, c_sus, c_p, c_m, dp_i, dm_i, rx_diff} <= rows[k].i[7:0];
            repeat (5) @(posedge ref_clk);
            m = {1'h1, {2{rows[k].e[7]}}, !rows[k].i[5], 1'h1, rows[k].e[3], 1'h1, rows[k].e[1]};
            seen = {line_oe, dp_o, dm_o, diff_receive_out, tx_data_plus_oe, tx_data_plus_o, se0_minus_oe, se0_minus_o};
            check(seen & m, rows[k].e & m, "table row");
        end
        axi_wr(CTRL_OFFSET, 32'h4, r);
        @(posedge ref_clk);
        {bidir, c_oe, c_sus, dp_i, dm_i, rx_diff} <= 6'h15;
        repeat (30) @(posedge ref_clk);
        axi_rd(STATUS_OFFSET, d, r);
        check(d[7:6], 2'h3, "log full");
        axi_wr(CTRL_OFFSET, 32'h0, r);
        repeat (16) begin
            axi_rd(RXLOG_OFFSET, d, r);
            check({d[8], d[2:0]}, 4'hd, "log entry");
        end
        axi_rd(RXLOG_OFFSET, d, r);
        check(d[8], 1'h0, "log empty");
        axi_rd(STATUS_OFFSET, d, r);
        check(d[7:6], 2'h0, "status empty");
        rstn <= 1'h0;
        repeat (3) @(posedge ref_clk);
        check(diff_receive_out, 1'h0, "receive in reset");
        check(por_active, 1'h1, "pulse in second reset");
        rstn <= 1'h1;
        por_len();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire

// File: verification/uft_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module uft_link_model (
    input  wire logic ref_clk,     // Clock
    input  wire logic cmd_reset_n, // Wanted reset pin
    input  wire logic cmd_oe_n,    // Wanted output enable
    input  wire logic cmd_suspend, // Wanted suspend
    input  wire logic cmd_p,       // Wanted data-plus level
    input  wire logic cmd_m,       // Wanted se0-minus level
    input  wire logic bidir,       // Bidirectional pins
    input  wire logic p_o,         // Device data-plus drive
    input  wire logic p_oe,        // Device data-plus enable
    input  wire logic m_o,         // Device se0-minus drive
    input  wire logic m_oe,        // Device se0-minus enable
    output wire logic reset_pin_n, // Reset pin
    output wire logic oe_n,        // Output enable
    output wire logic suspend,     // Suspend
    output wire logic pin_p,       // Data-plus wire level
    output wire logic pin_m        // Se0-minus wire level
);
    logic rst_q = 1'h1, oe_q = 1'h1, sus_q = 1'h0, p_q = 1'h0, m_q = 1'h0;
    logic drv_q = 1'h1, lp_q = 1'h0, lm_q = 1'h0;
    // ----------------------------------------
    // Requests change just after the edge
    // ----------------------------------------
    always @(posedge ref_clk) begin
        rst_q <= cmd_reset_n;
        oe_q  <= cmd_oe_n;
        sus_q <= cmd_suspend;
        p_q   <= cmd_p;
        m_q   <= cmd_m;
        drv_q <= !bidir || !cmd_oe_n;
        lp_q  <= pin_p;
        lm_q  <= pin_m;
    end
    assign reset_pin_n = rst_q;
    assign oe_n        = oe_q;
    assign suspend     = sus_q;
    // Released pin toggles, never keeps a stale level
    assign pin_p = p_oe ? p_o : (drv_q ? p_q : !lp_q);
    assign pin_m = m_oe ? m_o : (drv_q ? m_q : !lm_q);
endmodule : uft_link_model
`default_nettype wire
